// ---- common/mac_trx_pkg.sv ----
// Purpose: shared constants and carriers for the tx status / rx control block
// Assumes: AHB-Lite word access, register index times four is the byte address
// Notes: one clock domain, 125 MHz
package mac_trx_pkg;
	// ==========
	// register indices and address width
	localparam logic [7:0] IDX_TX_STATUS = 8'h72;
	localparam logic [7:0] IDX_RX_CTRL_ONE = 8'h74;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h78;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h7A;
	localparam int ADDR_W = 10;
	// ==========
	// transmit status field positions
	localparam int TXS_LATE_BIT = 13;
	localparam int TXS_RETRY_BIT = 12;
	localparam int TXS_TAG_LSB = 0;
	localparam int TAG_W = 6;
	localparam logic [15:0] TXS_RESET = 16'h0000;
	// ==========
	// receive control field positions
	localparam int RXC_FLUSH_BIT = 15;
	localparam int RXC_UDP_BIT = 14;
	localparam int RXC_TCP_BIT = 13;
	localparam int RXC_IP_BIT = 12;
	localparam int RXC_UNI_BIT = 11;
	localparam int RXC_PAUSE_BIT = 10;
	localparam int RXC_BADCRC_BIT = 9;
	localparam int RXC_RUN_BIT = 0;
	localparam logic [15:0] RXC_RESET = 16'h0800;
	localparam logic [15:0] RXC_WMASK = 16'hFE01;
	// ==========
	// interrupt bits
	localparam int IRQ_W = 3;
	localparam int IRQ_TX_DONE_BIT = 0;
	localparam int IRQ_RX_OK_BIT = 1;
	localparam int IRQ_RX_DROP_BIT = 2;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;
	// ==========
	// pause timing: one quantum is 512 bit times at 100 Mb/s
	localparam int CLK_PERIOD_NS = 8;
	localparam int PAUSE_QUANTUM_NS = 5120;
	localparam int PAUSE_QUANTUM_CYC = PAUSE_QUANTUM_NS / CLK_PERIOD_NS;
	localparam int PQ_CNT_W = 10;
	// ==========
	// carriers
	typedef struct packed {
		logic late_collision;
		logic retry_limit;
		logic [TAG_W-1:0] tag;
	} tx_result_type;
	typedef struct packed {
		logic crc_ok;
		logic is_ip;
		logic ip_sum_ok;
		logic is_tcp;
		logic tcp_sum_ok;
		logic is_udp;
		logic udp_sum_ok;
		logic is_unicast;
		logic addr_match;
	} rx_frame_type;
endpackage

// ---- src/mac_tx_status_rx_control.sv ----
// Purpose: transmit status word, receive control word, pause hold and rx frame gate
// Assumes: tx and rx event inputs come from logic on clk; AHB-Lite zero wait slave
// Notes: outputs all registered; interrupt is level, status bits write-one-to-clear
`timescale 1ns/1ns

module mac_tx_status_rx_control (
	input wire logic clk,
	input wire logic nrst,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic irq,
	// transmit side
	input wire logic tx_done,
	input wire mac_trx_pkg::tx_result_type tx_result,
	output logic tx_hold,
	// flow control
	input wire logic full_duplex,
	input wire logic pause_rx,
	input wire logic [15:0] pause_quanta,
	// receive side
	input wire logic rx_frame_start,
	input wire logic rx_frame_end,
	input wire mac_trx_pkg::rx_frame_type rx_frame,
	output logic rx_frame_accept,
	output logic rx_frame_drop,
	output logic rx_busy,
	output logic rx_queue_clear,
	output logic rx_ptr_reset
);
	typedef enum logic [1:0] {RX_STOPPED, RX_IDLE, RX_FRAME} rx_state_type;

	// word index hit: byte address must be four times the index
	function automatic logic idx_hit(input logic [mac_trx_pkg::ADDR_W-1:0] a,
			input logic [7:0] idx);
		idx_hit = (a == {idx, 2'b00});
	endfunction

	// ==========
	// state
	logic [15:0] tx_status_q, tx_status_d;
	logic [15:0] rx_ctrl_q, rx_ctrl_d;
	logic [mac_trx_pkg::IRQ_W-1:0] irq_stat_q, irq_stat_d;
	logic [mac_trx_pkg::IRQ_W-1:0] irq_mask_q, irq_mask_d;
	logic wr_pend_q;
	logic [mac_trx_pkg::ADDR_W-1:0] wr_addr_q;
	logic [31:0] hrdata_q, hrdata_d;
	rx_state_type rx_state_q, rx_state_d;
	logic accept_q, drop_q;
	logic [15:0] pause_left_q, pause_left_d;
	logic [mac_trx_pkg::PQ_CNT_W-1:0] pause_sub_q, pause_sub_d;
	logic tx_hold_q, irq_q, clear_q;
	logic busy_q, hreadyout_q, hresp_q;

	// ==========
	// bus decode
	wire addr_phase = hsel && htrans[1] && hready;
	wire rd_req = addr_phase && !hwrite;
	wire [mac_trx_pkg::ADDR_W-1:0] req_addr = haddr[mac_trx_pkg::ADDR_W-1:0];
	// transmit status is read only, so its write strobe is not decoded
	wire wr_rxc = wr_pend_q && idx_hit(wr_addr_q, mac_trx_pkg::IDX_RX_CTRL_ONE);
	wire wr_ist = wr_pend_q && idx_hit(wr_addr_q, mac_trx_pkg::IDX_IRQ_STATUS);
	wire wr_imk = wr_pend_q && idx_hit(wr_addr_q, mac_trx_pkg::IDX_IRQ_MASK);

	// control field views
	wire flush_en = rx_ctrl_q[mac_trx_pkg::RXC_FLUSH_BIT];
	wire udp_en = rx_ctrl_q[mac_trx_pkg::RXC_UDP_BIT];
	wire tcp_en = rx_ctrl_q[mac_trx_pkg::RXC_TCP_BIT];
	wire ip_en = rx_ctrl_q[mac_trx_pkg::RXC_IP_BIT];
	wire uni_en = rx_ctrl_q[mac_trx_pkg::RXC_UNI_BIT];
	wire pause_en = rx_ctrl_q[mac_trx_pkg::RXC_PAUSE_BIT];
	wire badcrc_en = rx_ctrl_q[mac_trx_pkg::RXC_BADCRC_BIT];
	wire run_en = rx_ctrl_q[mac_trx_pkg::RXC_RUN_BIT];

	// ==========
	// transmit status: whole word replaced per finished frame
	always_comb begin
		tx_status_d = tx_status_q;
		if (tx_done) begin
			tx_status_d = mac_trx_pkg::TXS_RESET;
			tx_status_d[mac_trx_pkg::TXS_LATE_BIT] = tx_result.late_collision;
			tx_status_d[mac_trx_pkg::TXS_RETRY_BIT] = tx_result.retry_limit;
			tx_status_d[mac_trx_pkg::TXS_TAG_LSB +: mac_trx_pkg::TAG_W] = tx_result.tag;
		end
	end

	// receive control: only implemented bits take writes
	assign rx_ctrl_d = wr_rxc ? (hwdata[15:0] & mac_trx_pkg::RXC_WMASK) : rx_ctrl_q;

	// ==========
	// receive frame verdict
	wire bad_udp = udp_en && rx_frame.is_udp && !rx_frame.udp_sum_ok;
	wire bad_tcp = tcp_en && rx_frame.is_tcp && !rx_frame.tcp_sum_ok;
	wire bad_ip = ip_en && rx_frame.is_ip && !rx_frame.ip_sum_ok;
	wire bad_crc = !rx_frame.crc_ok && !badcrc_en;
	wire bad_addr = rx_frame.is_unicast && !(uni_en && rx_frame.addr_match);
	wire frame_bad = bad_udp || bad_tcp || bad_ip || bad_crc || bad_addr;
	wire frame_close = (rx_state_q == RX_FRAME) && rx_frame_end;
	wire accept_d = frame_close && !frame_bad && !flush_en;
	wire drop_d = frame_close && (frame_bad || flush_en);

	// rx run state: disable only takes hold between frames
	always_comb begin
		rx_state_d = rx_state_q;
		case (rx_state_q)
			RX_STOPPED: begin
				if (run_en && !flush_en) begin
					rx_state_d = RX_IDLE;
				end
			end
			RX_IDLE: begin
				if (!run_en || flush_en) begin
					rx_state_d = RX_STOPPED;
				end else if (rx_frame_start) begin
					rx_state_d = RX_FRAME;
				end
			end
			RX_FRAME: begin
				if (rx_frame_end) begin
					rx_state_d = run_en ? RX_IDLE : RX_STOPPED;
				end
			end
			default: rx_state_d = RX_STOPPED;
		endcase
	end

	// ==========
	// pause timer: quanta times slot length, full duplex only
	wire pause_take = pause_rx && pause_en && full_duplex;
	wire sub_wrap = (pause_sub_q == mac_trx_pkg::PQ_CNT_W'(mac_trx_pkg::PAUSE_QUANTUM_CYC - 1));
	always_comb begin
		pause_left_d = pause_left_q;
		pause_sub_d = pause_sub_q;
		if (pause_take) begin
			pause_left_d = pause_quanta;
			pause_sub_d = '0;
		end else if (!pause_en || !full_duplex) begin
			pause_left_d = 16'h0000;
			pause_sub_d = '0;
		end else if (pause_left_q != 16'h0000) begin
			pause_sub_d = sub_wrap ? '0 : pause_sub_q + 1'b1;
			if (sub_wrap) begin
				pause_left_d = pause_left_q - 16'h0001;
			end
		end
	end

	// ==========
	// interrupt status: set beats a same-cycle clear
	wire [mac_trx_pkg::IRQ_W-1:0] irq_events = {drop_d, accept_d, tx_done};
	wire [mac_trx_pkg::IRQ_W-1:0] irq_clr = wr_ist ? hwdata[mac_trx_pkg::IRQ_W-1:0] : '0;
	assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_events;
	assign irq_mask_d = wr_imk ? hwdata[mac_trx_pkg::IRQ_W-1:0] : irq_mask_q;

	// read mux from next values so a read right after a write sees it
	always_comb begin
		hrdata_d = 32'h0000_0000;
		if (idx_hit(req_addr, mac_trx_pkg::IDX_TX_STATUS)) begin
			hrdata_d[15:0] = tx_status_d;
		end else if (idx_hit(req_addr, mac_trx_pkg::IDX_RX_CTRL_ONE)) begin
			hrdata_d[15:0] = rx_ctrl_d;
		end else if (idx_hit(req_addr, mac_trx_pkg::IDX_IRQ_STATUS)) begin
			hrdata_d[mac_trx_pkg::IRQ_W-1:0] = irq_stat_d;
		end else if (idx_hit(req_addr, mac_trx_pkg::IDX_IRQ_MASK)) begin
			hrdata_d[mac_trx_pkg::IRQ_W-1:0] = irq_mask_d;
		end
	end

	// ==========
	// bus pipeline
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
			hrdata_q <= 32'h0000_0000;
		end else begin
			wr_pend_q <= addr_phase && hwrite;
			wr_addr_q <= req_addr;
			if (rd_req) begin
				hrdata_q <= hrdata_d;
			end
		end
	end

	// transmit status word, last frame only
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tx_status_q <= mac_trx_pkg::TXS_RESET;
		end else begin
			tx_status_q <= tx_status_d;
		end
	end

	// receive control word
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_ctrl_q <= mac_trx_pkg::RXC_RESET;
		end else begin
			rx_ctrl_q <= rx_ctrl_d;
		end
	end

	// interrupt status, sticky until written one
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_stat_q <= mac_trx_pkg::IRQ_RESET;
		end else begin
			irq_stat_q <= irq_stat_d;
		end
	end

	// interrupt mask
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_mask_q <= mac_trx_pkg::IRQ_RESET;
		end else begin
			irq_mask_q <= irq_mask_d;
		end
	end

	// rx run state and its busy flag, kept in step
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_state_q <= RX_STOPPED;
			busy_q <= 1'b0;
		end else begin
			rx_state_q <= rx_state_d;
			busy_q <= (rx_state_d == RX_FRAME);
		end
	end

	// one cycle verdict pulses
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			accept_q <= 1'b0;
			drop_q <= 1'b0;
		end else begin
			accept_q <= accept_d;
			drop_q <= drop_d;
		end
	end

	// pause timer counters
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pause_left_q <= 16'h0000;
			pause_sub_q <= '0;
		end else begin
			pause_left_q <= pause_left_d;
			pause_sub_q <= pause_sub_d;
		end
	end

	// registered outputs
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tx_hold_q <= 1'b0;
			irq_q <= 1'b0;
			clear_q <= 1'b0;
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
		end else begin
			tx_hold_q <= (pause_left_d != 16'h0000);
			irq_q <= |(irq_stat_d & irq_mask_d);
			clear_q <= rx_ctrl_d[mac_trx_pkg::RXC_FLUSH_BIT];
			hreadyout_q <= 1'b1; // zero wait states
			hresp_q <= 1'b0; // always okay
		end
	end

	// outputs straight from flops
	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;
	assign hrdata = hrdata_q;
	assign irq = irq_q;
	assign tx_hold = tx_hold_q;
	assign rx_frame_accept = accept_q;
	assign rx_frame_drop = drop_q;
	assign rx_busy = busy_q;
	assign rx_queue_clear = clear_q;
	assign rx_ptr_reset = clear_q;
endmodule

// ---- verification/ahb_host.sv ----
// Purpose: host model, single word bus transfers
// Assumes: okay response only
// Notes: waits on hready, no fixed latency
`timescale 1ns/1ns
module ahb_host (
	input logic clk,
	input logic hready,
	input logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	// idle bus at time zero
	initial begin
		hsel = 1'b0;
		haddr = '0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = '0;
	end
	// address phase held until ready, data taken at data phase edge
	task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] q);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'b010;
		htrans <= 2'b10;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		q = hrdata;
	endtask
endmodule

// ---- verification/mac_tx_status_rx_control_assertions.sv ----
// Purpose: port level checks of the rx gate, flush and pause hold
// Assumes: design top ports only
// Notes: bound to every instance of the top
`timescale 1ns/1ns
module mac_tx_status_rx_control_chk (
	input logic clk,
	input logic nrst,
	input logic full_duplex,
	input logic pause_rx,
	input logic tx_hold,
	input logic rx_frame_end,
	input mac_trx_pkg::rx_frame_type rx_frame,
	input logic rx_busy,
	input logic rx_frame_accept,
	input logic rx_frame_drop,
	input logic rx_queue_clear,
	input logic rx_ptr_reset
);
	// ==========
	// assertions
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	wire closing = rx_frame_end && rx_busy;
	AST_HOLD_FD:
		assert property (tx_hold && !full_duplex |=> !tx_hold) else $error("hold kept in half");
	AST_HALF_IGNORE:
		assert property (pause_rx && !full_duplex && !tx_hold |=> !tx_hold) else $error("pause obeyed");
	AST_HOLD_CAUSE:
		assert property ($rose(tx_hold) |-> $past(pause_rx) && $past(full_duplex))
			else $error("hold uncaused");
	AST_NO_SPURIOUS:
		assert property (rx_frame_accept || rx_frame_drop |-> $past(closing)) else $error("stray pulse");
	AST_ONE_OF:
		assert property (closing |=> rx_frame_accept != rx_frame_drop) else $error("no verdict");
	AST_FLUSH_PAIR:
		assert property (rx_queue_clear == rx_ptr_reset) else $error("flush outputs differ");
	AST_FLUSH_DROP:
		assert property (closing && rx_queue_clear |=> rx_frame_drop) else $error("flush kept frame");
	AST_FLUSH_STOPS:
		assert property (rx_queue_clear && !rx_busy |=> !rx_busy) else $error("frame began in flush");
	AST_UNI_DROP:
		assert property (closing && rx_frame.is_unicast && !rx_frame.addr_match |=> rx_frame_drop)
			else $error("unmatched unicast kept");
	// main scenarios reached
	cover property (rx_frame_accept);
	cover property (rx_frame_drop);
	cover property ($rose(tx_hold));
endmodule

bind mac_tx_status_rx_control mac_tx_status_rx_control_chk u_chk (.*);

// ---- verification/mac_tx_status_rx_control_tb_top.sv ----
// Purpose: directed bench for tx status and rx control
// Assumes: zero wait bus, host model drives the bus
// Notes: one task per scenario
`timescale 1ns/1ns
module mac_tx_status_rx_control_tb_top;
	localparam logic [31:0] A_TXS = {22'h0, mac_trx_pkg::IDX_TX_STATUS, 2'b00};
	localparam logic [31:0] A_RXC = {22'h0, mac_trx_pkg::IDX_RX_CTRL_ONE, 2'b00};
	localparam logic [31:0] A_IST = {22'h0, mac_trx_pkg::IDX_IRQ_STATUS, 2'b00};
	localparam logic [31:0] A_IMK = {22'h0, mac_trx_pkg::IDX_IRQ_MASK, 2'b00};
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic hsel, hwrite, hready, hreadyout, hresp, irq, tx_done, tx_hold, full_duplex, pause_rx;
	logic rx_frame_start, rx_frame_end, rx_frame_accept, rx_frame_drop, rx_busy;
	logic rx_queue_clear, rx_ptr_reset;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [15:0] pause_quanta;
	mac_trx_pkg::tx_result_type tx_result;
	mac_trx_pkg::rx_frame_type rx_frame;
	int num_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	assign hready = hreadyout;
	always #4 clk = ~clk;
	mac_tx_status_rx_control u_dut (
		.clk(clk),
		.nrst(nrst),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.irq(irq),
		.tx_done(tx_done),
		.tx_result(tx_result),
		.tx_hold(tx_hold),
		.full_duplex(full_duplex),
		.pause_rx(pause_rx),
		.pause_quanta(pause_quanta),
		.rx_frame_start(rx_frame_start),
		.rx_frame_end(rx_frame_end),
		.rx_frame(rx_frame),
		.rx_frame_accept(rx_frame_accept),
		.rx_frame_drop(rx_frame_drop),
		.rx_busy(rx_busy),
		.rx_queue_clear(rx_queue_clear),
		.rx_ptr_reset(rx_ptr_reset)
	);
	ahb_host u_host (.clk, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);
	// ==========
	// helpers
	task chk(input logic [31:0] s, e);
		total_checks++;
		if (s !== e) begin
			num_errors++;
			$display("BAD %0t got %h want %h", $time, s, e);
		end
	endtask
	task wr(input logic [31:0] a, d);
		u_host.xfer(1'b1, a, d, q);
	endtask
	task rd(input logic [31:0] a, e);
		u_host.xfer(1'b0, a, 32'h0000_0000, q);
		chk(q, e);
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task beg();
		@(posedge clk) rx_frame_start <= 1'b1;
		@(posedge clk) rx_frame_start <= 1'b0;
	endtask
	// close a frame, check {accept, drop}
	task fin(input logic [8:0] f, input logic [1:0] e);
		@(posedge clk);
		rx_frame_end <= 1'b1;
		rx_frame <= f;
		@(posedge clk) rx_frame_end <= 1'b0;
		#1 chk({rx_frame_accept, rx_frame_drop}, e);
		cyc(2);
	endtask
	task fr(input logic [31:0] c, input logic [8:0] f, input logic [1:0] e);
		wr(A_RXC, c);
		beg();
		fin(f, e);
	endtask
	task sendtx(input logic [7:0] r);
		@(posedge clk);
		tx_done <= 1'b1;
		tx_result <= r;
		@(posedge clk) tx_done <= 1'b0;
	endtask
	task pause(input logic fd);
		@(posedge clk);
		full_duplex <= fd;
		pause_rx <= 1'b1;
		@(posedge clk) pause_rx <= 1'b0;
		#1;
	endtask
	// ==========
	// scenarios
	task t_regs();
		rd(A_TXS, 32'h0000_0000);
		chk({hreadyout, hresp}, 2'b10);
		rd(A_RXC, 32'h0000_0800);
		wr(A_RXC, 32'hFFFF_FFFF);
		rd(A_RXC, 32'h0000_FE01);
		rd(32'h0000_0100, 32'h0000_0000);
		$display("done regs");
	endtask
	task t_tx();
		sendtx(8'hAA);
		rd(A_TXS, 32'h0000_202A);
		sendtx(8'h7F);
		rd(A_TXS, 32'h0000_103F);
		wr(A_TXS, 32'hFFFF_FFFF);
		rd(A_TXS, 32'h0000_103F);
		rd(A_IST, 32'h0000_0001);
		wr(A_IMK, 32'h0000_0001);
		cyc(2);
		chk(irq, 1);
		wr(A_IST, 32'h0000_0001);
		cyc(2);
		chk(irq, 0);
		$display("done tx");
	endtask
	task t_rx();
		fr(32'h0801, 9'h100, 2'b10);
		fr(32'h0801, 9'h108, 2'b10);
		fr(32'h0801, 9'h000, 2'b01);
		fr(32'h0801, 9'h103, 2'b10);
		fr(32'h0801, 9'h102, 2'b01);
		fr(32'h7201, 9'h108, 2'b01);
		fr(32'h7201, 9'h120, 2'b01);
		fr(32'h7201, 9'h180, 2'b01);
		fr(32'h7201, 9'h1FC, 2'b10);
		fr(32'h7201, 9'h000, 2'b10);
		fr(32'h7201, 9'h103, 2'b01);
		$display("done rx");
	endtask
	task t_stop();
		wr(A_RXC, 32'h0801);
		beg();
		#1 chk(rx_busy, 1);
		wr(A_RXC, 32'h0800);
		fin(9'h100, 2'b10);
		beg();
		#1 chk(rx_busy, 0);
		fin(9'h100, 2'b00);
		wr(A_RXC, 32'h0801);
		beg();
		wr(A_RXC, 32'h8800);
		fin(9'h100, 2'b01);
		chk({rx_queue_clear, rx_ptr_reset}, 2'b11);
		wr(A_RXC, 32'h0800);
		cyc(2);
		#1 chk({rx_queue_clear, rx_ptr_reset}, 2'b00);
		$display("done stop");
	endtask
	task t_pause();
		wr(A_RXC, 32'h0C00);
		pause(1'b1);
		chk(tx_hold, 1);
		cyc(mac_trx_pkg::PAUSE_QUANTUM_CYC - 1);
		#1 chk(tx_hold, 1);
		cyc(1);
		#1 chk(tx_hold, 0);
		pause(1'b0);
		cyc(1);
		#1 chk(tx_hold, 0);
		wr(A_RXC, 32'h0800);
		pause(1'b1);
		cyc(1);
		#1 chk(tx_hold, 0);
		$display("done pause");
	endtask
	task tally_and_finish();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ==========
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	// main sequence
	initial begin
		{tx_done, full_duplex, pause_rx, rx_frame_start, rx_frame_end} = '0;
		tx_result = '0;
		rx_frame = '0;
		pause_quanta = 16'h0001;
		cyc(16);
		nrst <= 1'b1;
		t_regs();
		t_tx();
		t_rx();
		t_stop();
		t_pause();
		tally_and_finish();
	end
endmodule
